//--- design/cofc_comparator_control.v
/*
  Digital control around an analog comparator: registers, input and analog
  settings, polarity, blanking, glitch filter with prescaled sampling, and
  routing of the result to timer inputs.
  Assumes one clock; the analog result and timer blanking outputs are
  asynchronous and are synchronised here. The low-speed clock choice is
  exported for the clock mux outside this block.

  // How it works
  // - bit 20 picks system or low-speed clock
  // - bit 17 reads live comparator output
  // - bits 16:14 pick blanking timer channel
  // - bits 13:12 set hysteresis level
  // - bit 11 inverts comparator output
  // - bits 10:7 route output to timer input
  // - bits 5:4 choose positive input
  // - bits 2:1 choose negative input
  // - bit 0 enables; all reset to zero
  // - filter window is window field plus one
  // - output flips on enough opposite samples
  // - sample every divider plus one cycles
  // - lock freezes control until reset
*/
`timescale 1ns/1ps
`include "cofc_defines.vh"

module cofc_comparator_control (
  input  wire                    clock,
  input  wire                    reset,
  input  wire [`COFC_ADDR_W-1:0] busAddr,
  input  wire [31:0]             busWriteData,
  input  wire                    busWrite,
  input  wire                    busRead,
  output reg  [31:0]             busReadData,
  input  wire                    analogResult,
  input  wire                    timerABlank,
  input  wire                    timerBBlank,
  output reg                     comparatorEnable,
  output reg                     lowPowerMode,
  output reg                     lowSpeedClock,
  output reg  [1:0]              hysteresisLevel,
  output reg  [1:0]              positiveInputChoice,
  output reg  [1:0]              negativeInputChoice,
  output reg                     timerABreakInput,
  output reg                     timerACaptureInputOne,
  output reg                     timerAReferenceClear,
  output reg                     timerBBreakInput,
  output reg                     timerBCaptureInputOne,
  output reg                     timerBReferenceClear,
  output reg                     timerCCaptureInputOne,
  output reg                     timerCReferenceClear,
  output reg                     lowPowerTimerTrigger,
  output reg                     comparatorLevel
);
  reg  [31:0] control_reg;
  reg  [31:0] filterCtrl_reg;
  reg  [31:0] prescale_reg;
  reg         freeze_reg;
  reg  [15:0] divCount_reg;
  reg  [15:0] divCount_next;
  reg  [`COFC_WIN_MAX-1:0] window_reg;
  reg         filtered_reg;
  reg         filtered_next;
  reg         blanked;
  reg  [5:0]  oppositeCount;
  reg  [`COFC_WIN_MAX-1:0] windowMask;
  wire        resultSync;
  wire        blankASync;
  wire        blankBSync;
  wire        sampleTick;
  wire [4:0]  windowField;
  wire [4:0]  changeField;
  wire        filterOn;
  wire        polarized;
  wire        finalLevel;
  integer     i;

  // Analog result and timer outputs come from other domains
  cofc_sync2 u_syncResult (.clock(clock), .reset(reset), .asyncIn(analogResult), .syncOut(resultSync));
  cofc_sync2 u_syncBlankA (.clock(clock), .reset(reset), .asyncIn(timerABlank), .syncOut(blankASync));
  cofc_sync2 u_syncBlankB (.clock(clock), .reset(reset), .asyncIn(timerBBlank), .syncOut(blankBSync));

  assign windowField = filterCtrl_reg[`COFC_F_WINDOW];
  assign changeField = filterCtrl_reg[`COFC_F_CHANGE];
  assign filterOn    = filterCtrl_reg[`COFC_B_FILTON];

  // Register writes
  always @(posedge clock) begin
    if (reset) begin
      control_reg    <= `COFC_RST_CTRL;
      filterCtrl_reg <= `COFC_RST_FILC;
      prescale_reg   <= `COFC_RST_FILP;
      freeze_reg     <= 1'b0;
    end else if (busWrite) begin
      case (busAddr)
        `COFC_OFF_CTRL: begin
          if (!freeze_reg) begin
            control_reg <= busWriteData & `COFC_CTRL_WMASK;
          end
        end
        `COFC_OFF_FILC: begin
          filterCtrl_reg <= busWriteData & `COFC_FILC_WMASK;
        end
        `COFC_OFF_FILP: begin
          prescale_reg <= busWriteData & `COFC_FILP_WMASK;
        end
        `COFC_OFF_LOCK: begin
          // Write once: only a set sticks, cleared only by reset
          if (busWriteData[0]) begin
            freeze_reg <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stands one cycle after the strobe only
  always @(posedge clock) begin
    if (reset) begin
      busReadData <= 32'h00000000;
    end else if (busRead) begin
      case (busAddr)
        `COFC_OFF_CTRL: begin
          busReadData <= control_reg | ({31'h00000000, comparatorLevel} << `COFC_B_OUT);
        end
        `COFC_OFF_FILC: begin
          busReadData <= filterCtrl_reg;
        end
        `COFC_OFF_FILP: begin
          busReadData <= prescale_reg;
        end
        `COFC_OFF_LOCK: begin
          busReadData <= {31'h00000000, freeze_reg};
        end
        default: begin
          busReadData <= 32'h00000000;
        end
      endcase
    end else begin
      busReadData <= 32'h00000000;
    end
  end

  // Analog settings
  always @(posedge clock) begin
    if (reset) begin
      comparatorEnable    <= 1'b0;
      lowPowerMode        <= 1'b0;
      lowSpeedClock       <= 1'b0;
      hysteresisLevel     <= 2'h0;
      positiveInputChoice <= 2'h0;
      negativeInputChoice <= 2'h0;
    end else begin
      comparatorEnable    <= control_reg[`COFC_B_ENABLE];
      lowPowerMode        <= control_reg[`COFC_B_POWER];
      lowSpeedClock       <= control_reg[`COFC_B_CLKCHOICE];
      hysteresisLevel     <= control_reg[`COFC_F_HYSTERESIS_LEVEL];
      positiveInputChoice <= control_reg[`COFC_F_POS];
      negativeInputChoice <= control_reg[`COFC_F_NEG];
    end
  end

  // Polarity first, then blanking; disabled comparator reads low
  assign polarized = (resultSync ^ control_reg[`COFC_B_INVERT]) & control_reg[`COFC_B_ENABLE];

  always @* begin
    case (control_reg[`COFC_F_BLANK])
      `COFC_BLANK_TIMA: blanked = polarized & ~blankASync;
      `COFC_BLANK_TIMB: blanked = polarized & ~blankBSync;
      default:          blanked = polarized;
    endcase
  end

  // Sample enable pulse
  assign sampleTick = (divCount_reg == 16'h0000);

  always @* begin
    if (sampleTick) begin
      divCount_next = prescale_reg[`COFC_F_DIVIDER];
    end else begin
      divCount_next = divCount_reg - 16'h0001;
    end
  end

  // Window of valid taps and count of samples opposite to the output
  always @* begin
    windowMask    = {`COFC_WIN_MAX{1'b0}};
    oppositeCount = 6'h00;
    for (i = 0; i < `COFC_WIN_MAX; i = i + 1) begin
      if (i <= windowField) begin
        windowMask[i] = 1'b1;
      end
    end
    for (i = 0; i < `COFC_WIN_MAX; i = i + 1) begin
      if (windowMask[i] && (window_reg[i] != filtered_reg)) begin
        oppositeCount = oppositeCount + 6'h01;
      end
    end
  end

  // Threshold above half the window keeps a single decision; not checked here
  always @* begin
    filtered_next = filtered_reg;
    if (oppositeCount >= {1'b0, changeField}) begin
      filtered_next = ~filtered_reg;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      divCount_reg <= 16'h0000;
      window_reg   <= {`COFC_WIN_MAX{1'b0}};
      filtered_reg <= 1'b0;
    end else if (!filterOn) begin
      // Track the raw level so enabling the filter starts without a glitch
      divCount_reg <= 16'h0000;
      window_reg   <= {`COFC_WIN_MAX{blanked}};
      filtered_reg <= blanked;
    end else begin
      divCount_reg <= divCount_next;
      if (sampleTick) begin
        window_reg   <= {window_reg[`COFC_WIN_MAX-2:0], blanked};
        filtered_reg <= filtered_next;
      end
    end
  end

  assign finalLevel = filterOn ? filtered_reg : blanked;

  // Output routing to a single timer input, or to both break inputs for code 4'hb
  always @(posedge clock) begin
    if (reset) begin
      comparatorLevel       <= 1'b0;
      timerABreakInput      <= 1'b0;
      timerACaptureInputOne <= 1'b0;
      timerAReferenceClear  <= 1'b0;
      timerBBreakInput      <= 1'b0;
      timerBCaptureInputOne <= 1'b0;
      timerBReferenceClear  <= 1'b0;
      timerCCaptureInputOne <= 1'b0;
      timerCReferenceClear  <= 1'b0;
      lowPowerTimerTrigger  <= 1'b0;
    end else begin
      comparatorLevel       <= finalLevel;
      timerABreakInput      <= finalLevel & ((control_reg[`COFC_F_ROUTE] == `COFC_RT_A_BRK) ||
                                             (control_reg[`COFC_F_ROUTE] == `COFC_RT_AB_BRK));
      timerACaptureInputOne <= finalLevel & (control_reg[`COFC_F_ROUTE] == `COFC_RT_A_CAP);
      timerAReferenceClear  <= finalLevel & (control_reg[`COFC_F_ROUTE] == `COFC_RT_A_CLR);
      timerBBreakInput      <= finalLevel & ((control_reg[`COFC_F_ROUTE] == `COFC_RT_B_BRK) ||
                                             (control_reg[`COFC_F_ROUTE] == `COFC_RT_AB_BRK));
      timerBCaptureInputOne <= finalLevel & (control_reg[`COFC_F_ROUTE] == `COFC_RT_B_CAP);
      timerBReferenceClear  <= finalLevel & (control_reg[`COFC_F_ROUTE] == `COFC_RT_B_CLR);
      timerCCaptureInputOne <= finalLevel & (control_reg[`COFC_F_ROUTE] == `COFC_RT_C_CAP);
      timerCReferenceClear  <= finalLevel & (control_reg[`COFC_F_ROUTE] == `COFC_RT_C_CLR);
      lowPowerTimerTrigger  <= finalLevel & (control_reg[`COFC_F_ROUTE] == `COFC_RT_LP_TRIG);
    end
  end
endmodule // cofc_comparator_control

//--- design/cofc_defines.vh
/*
  Offsets, field positions, reset values and codes of the comparator control block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef COFC_DEFINES_VH
`define COFC_DEFINES_VH

`define COFC_ADDR_W          8
`define COFC_OFF_CTRL        8'h10
`define COFC_OFF_FILC        8'h14
`define COFC_OFF_FILP        8'h18
`define COFC_OFF_LOCK        8'h0c

`define COFC_RST_CTRL        32'h00000000
`define COFC_RST_FILC        32'h00000000
`define COFC_RST_FILP        32'h00000000

`define COFC_CTRL_WMASK      32'h0019ffb7
`define COFC_FILC_WMASK      32'h000007ff
`define COFC_FILP_WMASK      32'h0000ffff

`define COFC_B_CLKCHOICE     20
`define COFC_B_POWER         19
`define COFC_B_OUT           17
`define COFC_F_BLANK         16:14
`define COFC_F_HYSTERESIS_LEVEL          13:12
`define COFC_B_INVERT        11
`define COFC_F_ROUTE         10:7
`define COFC_F_POS           5:4
`define COFC_F_NEG           2:1
`define COFC_B_ENABLE        0

`define COFC_F_WINDOW        10:6
`define COFC_F_CHANGE        5:1
`define COFC_B_FILTON        0
`define COFC_F_DIVIDER       15:0

`define COFC_BLANK_NONE      3'h0
`define COFC_BLANK_TIMA      3'h1
`define COFC_BLANK_TIMB      3'h2

`define COFC_RT_A_BRK        4'h1
`define COFC_RT_A_CAP        4'h2
`define COFC_RT_A_CLR        4'h3
`define COFC_RT_B_CAP        4'h4
`define COFC_RT_B_CLR        4'h5
`define COFC_RT_C_CAP        4'h6
`define COFC_RT_C_CLR        4'h7
`define COFC_RT_AB_BRK       4'hb
`define COFC_RT_B_BRK        4'hc
`define COFC_RT_LP_TRIG      4'hd

`define COFC_WIN_MAX         32
`endif

//--- design/cofc_sync2.v
/*
  Two flip-flop synchroniser for one level.
  Assumes the input is asynchronous to clock.
*/
`timescale 1ns/1ps
`include "cofc_defines.vh"

module cofc_sync2 (
  input  wire clock,
  input  wire reset,
  input  wire asyncIn,
  output wire syncOut
);
  reg stageOne_reg;
  reg stageTwo_reg;

  always @(posedge clock) begin
    if (reset) begin
      stageOne_reg <= 1'b0;
      stageTwo_reg <= 1'b0;
    end else begin
      stageOne_reg <= asyncIn;
      stageTwo_reg <= stageOne_reg;
    end
  end

  assign syncOut = stageTwo_reg;
endmodule // cofc_sync2

//--- dv/cofc_ctrl_chk.sv
/* Port checker for the comparator control block.
   Assumes one clock and binding onto the block's top module. */
`timescale 1ns/1ps
`include "cofc_defines.vh"
module cofc_ctrl_chk (
  input wire                    clock,
  input wire                    reset,
  input wire [`COFC_ADDR_W-1:0] busAddr,
  input wire [31:0]             busWriteData,
  input wire                    busWrite,
  input wire                    busRead,
  input wire [31:0]             busReadData,
  input wire                    analogResult,
  input wire                    timerABlank,
  input wire                    comparatorEnable,
  input wire                    lowPowerMode,
  input wire                    lowSpeedClock,
  input wire [1:0]              hysteresisLevel,
  input wire                    timerABreakInput,
  input wire                    lowPowerTimerTrigger,
  input wire                    comparatorLevel
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Shadow of software settings, so checks need no internal probes
  reg        lock_reg;
  reg [31:0] ctrl_reg;
  reg        filtOn_reg;
  wire       ctrlWr = busWrite && busAddr == `COFC_OFF_CTRL && !lock_reg;
  always @(posedge clock) begin
    if (reset) begin
      lock_reg   <= 1'b0;
      ctrl_reg   <= 32'h0;
      filtOn_reg <= 1'b0;
    end else begin
      if (busWrite && busAddr == `COFC_OFF_LOCK && busWriteData[0]) lock_reg <= 1'b1;
      if (ctrlWr) ctrl_reg <= busWriteData;
      if (busWrite && busAddr == `COFC_OFF_FILC) filtOn_reg <= busWriteData[0];
    end
  end
  enable_copy_a: assert property (ctrlWr |-> ##2 comparatorEnable == $past(busWriteData[0], 2))
    else $error("enable differs from control write");
  settings_copy_a: assert property (ctrlWr |-> ##2 {lowSpeedClock, lowPowerMode, hysteresisLevel} ==
    {$past(busWriteData[20:19], 2), $past(busWriteData[13:12], 2)}) else $error("settings differ from write");
  lock_freeze_a: assert property (lock_reg && $past(lock_reg, 2) |=>
    $stable({comparatorEnable, lowPowerMode, hysteresisLevel})) else $error("settings moved while locked");
  level_read_a: assert property (busRead && busAddr == `COFC_OFF_CTRL |=>
    busReadData[17] == $past(comparatorLevel)) else $error("level bit differs from output");
  route_break_a: assert property ($past(ctrl_reg[10:7]) == 4'h1 |-> timerABreakInput == comparatorLevel)
    else $error("break input not following level");
  route_idle_a: assert property ($past(ctrl_reg[10:7]) != 4'hd |-> !lowPowerTimerTrigger)
    else $error("trigger driven while not routed");
  blank_low_a: assert property ((!filtOn_reg && ctrl_reg[16:14] == 3'h1 && timerABlank)[*4]
    |-> !comparatorLevel) else $error("level high while blanked");
  bypass_level_a: assert property ((!filtOn_reg && ctrl_reg[0] && ctrl_reg[16:14] == 3'h0
    && $stable(analogResult))[*4] |-> comparatorLevel == (analogResult ^ $past(ctrl_reg[11])))
    else $error("bypass level wrong");
  disabled_low_a: assert property ((!filtOn_reg && !ctrl_reg[0])[*4] |-> !comparatorLevel)
    else $error("level high while disabled");
endmodule // cofc_ctrl_chk
bind cofc_comparator_control cofc_ctrl_chk chk (.*);

//--- dv/cofc_timer_model.sv
/* Timer side model: channel-five outputs used for blanking.
   Assumes the bench commands each level; output changes after an edge. */
`timescale 1ns/1ps
module cofc_timer_model (
  input  wire clock,
  input  wire blankCmdA,
  input  wire blankCmdB,
  output reg  timerABlank = 1'b0,
  output reg  timerBBlank = 1'b0
);
  always @(posedge clock) begin
    timerABlank <= blankCmdA;
    timerBBlank <= blankCmdB;
  end
endmodule // cofc_timer_model

//--- dv/tb_top.sv
/* Self-checking bench for the comparator control block.
   Assumes the design, timer model and checker are compiled before it. */
`timescale 1ns/1ps
`include "cofc_defines.vh"
module tb_top;
  localparam logic [8:0] ROUTE_TAB [0:15] = '{9'h000, 9'h100, 9'h080, 9'h040, 9'h010, 9'h008, 9'h004,
    9'h002, 9'h000, 9'h000, 9'h000, 9'h120, 9'h020, 9'h001, 9'h000, 9'h000};
  reg         clock = 1'b0;
  reg         reset = 1'b1;
  reg  [7:0]  busAddr = 8'h00;
  reg  [31:0] busWriteData = 32'h0;
  reg         busWrite = 1'b0;
  reg         busRead = 1'b0;
  reg         analogResult = 1'b0;
  reg         blankCmdA = 1'b0;
  reg         blankCmdB = 1'b0;
  wire        timerABlank;
  wire        timerBBlank;
  wire [31:0] busReadData;
  wire [8:0]  routed;
  wire [8:0]  settings;
  wire        comparatorLevel;
  int         errCount = 0;
  int         checkCount = 0;
  int         cyc = 0;
  int         t1;
  cofc_comparator_control dut (.clock(clock), .reset(reset), .busAddr(busAddr), .busWriteData(busWriteData),
    .busWrite(busWrite), .busRead(busRead), .busReadData(busReadData), .analogResult(analogResult),
    .timerABlank(timerABlank), .timerBBlank(timerBBlank), .comparatorEnable(settings[0]),
    .lowPowerMode(settings[7]), .lowSpeedClock(settings[8]), .hysteresisLevel(settings[6:5]),
    .positiveInputChoice(settings[4:3]), .negativeInputChoice(settings[2:1]), .timerABreakInput(routed[8]),
    .timerACaptureInputOne(routed[7]), .timerAReferenceClear(routed[6]), .timerBBreakInput(routed[5]),
    .timerBCaptureInputOne(routed[4]), .timerBReferenceClear(routed[3]), .timerCCaptureInputOne(routed[2]),
    .timerCReferenceClear(routed[1]), .lowPowerTimerTrigger(routed[0]), .comparatorLevel(comparatorLevel));
  cofc_timer_model timers (.clock(clock), .blankCmdA(blankCmdA), .blankCmdB(blankCmdB),
    .timerABlank(timerABlank), .timerBBlank(timerBBlank));
  initial begin
    forever #25 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  task endSim;
    begin
      if (errCount == 0 && checkCount > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      checkCount = checkCount + 1;
      if (seen !== exp) begin
        errCount = errCount + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Extra edge after the strobe drops, so a following access never reassigns it
  task wr(input [7:0] a, input [31:0] d);
    begin
      busAddr <= a;
      busWriteData <= d;
      busWrite <= 1'b1;
      @(posedge clock);
      busWrite <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp, input string what);
    begin
      busAddr <= a;
      busRead <= 1'b1;
      @(posedge clock);
      busRead <= 1'b0;
      #1;
      check(busReadData, exp, what);
      @(posedge clock);
    end
  endtask
  task waitLevel(input lvl);
    int n;
    begin
      n = 0;
      do begin
        @(negedge clock);
        n = n + 1;
        if (n > 300) begin
          check(comparatorLevel, lvl, "level wait");
          endSim;
        end
      end while (comparatorLevel !== lvl);
      @(posedge clock);
    end
  endtask
  task glitch;
    begin
      analogResult <= 1'b1;
      repeat (2) @(posedge clock);
      analogResult <= 1'b0;
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rdc(`COFC_OFF_CTRL, 32'h0, "ctrl reset");
    rdc(`COFC_OFF_FILC, 32'h0, "filter reset");
    rdc(`COFC_OFF_FILP, 32'h0, "divider reset");
    rdc(8'h20, 32'h0, "unmapped");
    check({settings, routed, comparatorLevel}, 32'h0, "outputs reset");
    wr(`COFC_OFF_CTRL, 32'h001bffb7);
    repeat (4) @(posedge clock);
    rdc(`COFC_OFF_CTRL, 32'h001bffb7, "ctrl all");
    check(settings, 9'h1ff, "settings all");
    // Output bit written high while the level is low: must read back low
    wr(`COFC_OFF_CTRL, 32'h000a1023);
    repeat (4) @(posedge clock);
    rdc(`COFC_OFF_CTRL, 32'h00081023, "ctrl out bit");
    check(settings, 9'h0b3, "settings mixed");
    for (int c = 0; c < 16; c++) begin
      wr(`COFC_OFF_CTRL, 32'h801 | (c << 7));
      repeat (4) @(posedge clock);
      check(routed, ROUTE_TAB[c], "routing");
    end
    wr(`COFC_OFF_CTRL, 32'h4801);
    blankCmdA <= 1'b1;
    repeat (5) @(posedge clock);
    check(comparatorLevel, 1'b0, "blank a");
    wr(`COFC_OFF_CTRL, 32'h8801);
    repeat (4) @(posedge clock);
    check(comparatorLevel, 1'b1, "blank b idle");
    blankCmdB <= 1'b1;
    repeat (5) @(posedge clock);
    check(comparatorLevel, 1'b0, "blank b");
    blankCmdA <= 1'b0;
    blankCmdB <= 1'b0;
    // One-sample window: every output change lands on a sample tick
    wr(`COFC_OFF_FILP, 32'h9);
    wr(`COFC_OFF_FILC, 32'h3);
    wr(`COFC_OFF_CTRL, 32'h1);
    waitLevel(1'b0);
    analogResult <= 1'b1;
    waitLevel(1'b1);
    t1 = cyc;
    repeat (23) @(posedge clock);
    analogResult <= 1'b0;
    waitLevel(1'b0);
    check((cyc - t1) % 10, 32'h0, "tick spacing");
    wr(`COFC_OFF_FILP, 32'h0);
    wr(`COFC_OFF_FILC, 32'hc7);
    glitch;
    repeat (10) begin
      @(negedge clock);
      check(comparatorLevel, 1'b0, "glitch held");
    end
    @(posedge clock);
    wr(`COFC_OFF_FILC, 32'h45);
    glitch;
    waitLevel(1'b1);
    waitLevel(1'b0);
    wr(`COFC_OFF_LOCK, 32'h1);
    rdc(`COFC_OFF_LOCK, 32'h1, "lock");
    wr(`COFC_OFF_CTRL, 32'h00180000);
    repeat (3) @(posedge clock);
    rdc(`COFC_OFF_CTRL, 32'h1, "locked ctrl");
    check(settings, 9'h001, "locked settings");
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    wr(`COFC_OFF_CTRL, 32'h00080000);
    rdc(`COFC_OFF_CTRL, 32'h00080000, "unlocked ctrl");
    rdc(`COFC_OFF_LOCK, 32'h0, "lock cleared");
    endSim;
  end
endmodule // tb_top
